// File: hw/dqc_pkg.sv
// Shared constants and types for the acquisition card register port
package dqc_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int BYTE_W = 8;
    localparam int SAMPLE_W = 12;
    localparam int CHAN_W = 4;
    localparam int TIMER_CNT = 3;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    // Register offsets (byte offsets from the card base)
    localparam logic [ADDR_W-1:0] OFF_BRIDGE_ACTIVATE = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_BRIDGE_SETUP = 8'h02;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h05;
    localparam logic [ADDR_W-1:0] OFF_SAMPLE_LOW = 8'hC0;
    localparam logic [ADDR_W-1:0] OFF_SAMPLE_HIGH = 8'hC4;
    localparam logic [ADDR_W-1:0] OFF_ISO_IN = 8'hD8;
    localparam logic [ADDR_W-1:0] OFF_ISO_OUT = 8'hDC;
    localparam logic [ADDR_W-1:0] OFF_TIMER_BASE = 8'hE0;
    // Controller registers of the host end
    localparam logic [ADDR_W-1:0] OFF_CTL_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTL_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CTL_WDATA = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CTL_RDATA = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CTL_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_CTL_IRQ_EN = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_CTL_IRQ_CLR = 8'h18;
    // Field values
    localparam int ACTIVATE_BIT = 0;
    localparam logic [BYTE_W-1:0] SETUP_VALUE = 8'h00;
    localparam logic [BYTE_W-1:0] IRQ_MASK_ON = 8'h10;
    localparam logic [BYTE_W-1:0] IRQ_MASK_OFF = 8'h00;
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_READ_BIT = 1;
    localparam int CMD_BYTE_BIT = 2;
    localparam int ST_DONE = 0;
    localparam int ST_IRQ_LEVEL = 1;
    localparam int ST_BUSY = 2;
    localparam int NUM_EVENTS = 2;
    typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD} dqc_size_t;
endpackage : dqc_pkg

// File: hw/dqc_io_if.sv
// Host I/O link between controller and acquisition card
`timescale 1ns/1ps
interface dqc_io_if;
    import dqc_pkg::*;
    logic io_wr;
    logic io_rd;
    logic [ADDR_W-1:0] io_addr;
    logic [DATA_W-1:0] io_wdata;
    logic [3:0] io_be;
    logic [DATA_W-1:0] io_rdata;
    logic inta_n;
    modport card (input io_wr, io_rd, io_addr, io_wdata, io_be, output io_rdata, inta_n);
    modport host (output io_wr, io_rd, io_addr, io_wdata, io_be, input io_rdata, inta_n);
endinterface : dqc_io_if

// File: hw/dqc_card.sv
// Acquisition card register port: activation, IRQ mask, digital I/O, sample FIFO
// Overview of operation
// R1 - Three timers; channels one, two pace conversions
// R2 - Timer zero free, pins to user header
// R3 - Registers 32-bit, only low byte meaningful
// R4 - Host uses only 32-bit or 8-bit accesses
// R5 - Card inactive until activate bit written one; input register still reads while inactive
// R6 - Host writes zero to setup register first
// R7 - Mask value 10h enables interrupt line
// R8 - Input register returns eight isolated levels
// R9 - Output register writable, readable, drives outputs
// R10 - Each conversion result enters sample FIFO; code takes none while the card is inactive or the FIFO is full
// R11 - No DMA; host reads every entry
// R12 - Sample read as low, high-plus-channel bytes
// R13 - Card number one to four from jumper
// R14 - Upper bits read zero, writes ignored
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module dqc_card #(
    parameter int DEPTH = dqc_pkg::FIFO_DEPTH
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    dqc_io_if.card IO,
    input wire logic [dqc_pkg::BYTE_W-1:0] ISO_IN_BIT,
    output logic [dqc_pkg::BYTE_W-1:0] ISO_OUT_BIT,
    input wire logic [1:0] CARD_NUMBER_JUMPER,
    output logic [2:0] CARD_NUMBER,
    input wire logic SAMPLE_VALID,
    input wire logic [dqc_pkg::SAMPLE_W-1:0] SAMPLE_DATA,
    input wire logic [dqc_pkg::CHAN_W-1:0] SAMPLE_CHAN,
    output logic SAMPLE_READY,
    output logic CONV_TRIGGER,
    input wire logic [dqc_pkg::TIMER_CNT-1:0] TIMER_OUT,
    input wire logic USER_TIMER_CLK,
    input wire logic USER_TIMER_GATE,
    output logic USER_TIMER_OUT,
    output logic USER_TIMER_CLK_SYNC,
    output logic USER_TIMER_GATE_SYNC,
    output logic ACTIVE,
    output logic INT_PENDING
);
    import dqc_pkg::*;

    logic active_reg;
    logic setup_done_reg;
    logic irq_en_reg;
    logic [BYTE_W-1:0] out_reg;
    logic [BYTE_W-1:0] in_s1_reg, in_s2_reg;
    logic [1:0] jp_s1_reg, jp_s2_reg;
    logic [2:0] card_num_reg;
    logic [1:0] uclk_s1_reg, uclk_s2_reg;
    logic [TIMER_CNT-1:0] tmr_s1_reg, tmr_s2_reg, tmr_s3_reg;
    logic trig_reg;
    logic uout_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic inta_n_reg;
    logic [SAMPLE_W+CHAN_W-1:0] mem [DEPTH];
    logic [FIFO_AW-1:0] wp_reg, rp_reg;
    logic [FIFO_AW:0] cnt_reg;
    logic hi_pending_reg;
    logic ready_reg;
    logic [SAMPLE_W+CHAN_W-1:0] hold_reg;

    // Address decode; only the low byte lane carries data
    wire wr_low = IO.io_wr && IO.io_be[0]; // R4 R14
    wire wr_act = wr_low && IO.io_addr == OFF_BRIDGE_ACTIVATE;
    wire wr_setup = wr_low && IO.io_addr == OFF_BRIDGE_SETUP;
    wire wr_mask = IO.io_wr && IO.io_addr == OFF_IRQ_MASK;
    wire wr_out = wr_low && IO.io_addr == OFF_ISO_OUT && active_reg;
    wire [BYTE_W-1:0] wbyte = IO.io_wdata[BYTE_W-1:0];
    wire [BYTE_W-1:0] mask_byte = IO.io_wdata[BYTE_W-1:0];
    wire rd_low = IO.io_rd && IO.io_addr == OFF_SAMPLE_LOW && active_reg;
    wire rd_high = IO.io_rd && IO.io_addr == OFF_SAMPLE_HIGH && active_reg;
    wire fifo_empty = cnt_reg == '0;
    wire fifo_full = cnt_reg == (FIFO_AW+1)'(DEPTH);
    wire push = SAMPLE_VALID && !fifo_full && active_reg; // R10
    wire pop = rd_low && !fifo_empty; // R11 R12
    wire [SAMPLE_W+CHAN_W-1:0] head = mem[rp_reg];
    wire [SAMPLE_W+CHAN_W-1:0] push_word = {SAMPLE_CHAN, SAMPLE_DATA};
    wire [FIFO_AW:0] cnt_next = cnt_reg + (FIFO_AW+1)'(push) - (FIFO_AW+1)'(pop);
    wire [2:0] card_num_next = 3'({1'b0, jp_s2_reg}) + 3'h1; // R13
    wire tmr_rise = |(tmr_s2_reg[2:1] & ~tmr_s3_reg[2:1]); // R1

    // Read mux; upper 24 bits always zero, card data except the input register hidden while inactive
    logic [BYTE_W-1:0] rd_byte;
    always_comb begin
        rd_byte = '0;
        case (IO.io_addr)
            OFF_SAMPLE_LOW: rd_byte = active_reg ? head[BYTE_W-1:0] : '0; // R5 R12
            OFF_SAMPLE_HIGH: rd_byte = active_reg ? {hold_reg[SAMPLE_W+CHAN_W-1:SAMPLE_W],
                hold_reg[SAMPLE_W-1:BYTE_W]} : '0; // R12
            OFF_ISO_IN: rd_byte = in_s2_reg; // R8
            OFF_ISO_OUT: rd_byte = active_reg ? out_reg : '0; // R5 R9
            default: rd_byte = '0;
        endcase
    end
    wire [DATA_W-1:0] rdata_next = {{(DATA_W-BYTE_W){1'b0}}, rd_byte}; // R3 R14

    // Bridge control registers
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            active_reg <= 1'b0;
            setup_done_reg <= 1'b0;
            irq_en_reg <= 1'b0;
        end else begin
            if (wr_act) begin
                active_reg <= wbyte[ACTIVATE_BIT]; // R5
            end
            if (wr_setup && wbyte == SETUP_VALUE) begin
                setup_done_reg <= 1'b1; // R6
            end
            if (wr_mask) begin
                irq_en_reg <= mask_byte == IRQ_MASK_ON; // R7
            end
        end
    end

    // Digital output latch
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            out_reg <= '0;
        end else if (wr_out) begin
            out_reg <= wbyte; // R9
        end
    end

    // Synchronisers for pins
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            in_s1_reg <= '0;
            in_s2_reg <= '0;
            jp_s1_reg <= '0;
            jp_s2_reg <= '0;
            uclk_s1_reg <= '0;
            uclk_s2_reg <= '0;
            tmr_s1_reg <= '0;
            tmr_s2_reg <= '0;
            tmr_s3_reg <= '0;
        end else begin
            in_s1_reg <= ISO_IN_BIT;
            in_s2_reg <= in_s1_reg; // R8
            jp_s1_reg <= CARD_NUMBER_JUMPER;
            jp_s2_reg <= jp_s1_reg;
            uclk_s1_reg <= {USER_TIMER_GATE, USER_TIMER_CLK};
            uclk_s2_reg <= uclk_s1_reg; // R2
            tmr_s1_reg <= TIMER_OUT;
            tmr_s2_reg <= tmr_s1_reg;
            tmr_s3_reg <= tmr_s2_reg;
        end
    end

    // Card number, conversion pacing, user timer pass-through
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            card_num_reg <= 3'h1;
            trig_reg <= 1'b0;
            uout_reg <= 1'b0;
        end else begin
            card_num_reg <= card_num_next; // R13
            trig_reg <= tmr_rise && active_reg; // R1
            uout_reg <= tmr_s2_reg[0]; // R2
        end
    end

    // Sample FIFO storage
    always_ff @(posedge CORE_CLK) begin
        if (push) begin
            mem[wp_reg] <= push_word; // R10
        end
    end

    // FIFO pointers; reading the low byte pops and holds the high byte
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            hold_reg <= '0;
            hi_pending_reg <= 1'b0;
            ready_reg <= 1'b1;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + FIFO_AW'(1);
            end
            if (pop) begin
                rp_reg <= rp_reg + FIFO_AW'(1);
                hold_reg <= head; // R12
                hi_pending_reg <= 1'b1;
            end else if (rd_high) begin
                hi_pending_reg <= 1'b0;
            end
            cnt_reg <= cnt_next;
            ready_reg <= cnt_next != (FIFO_AW+1)'(DEPTH); // R10
        end
    end

    // Read data and interrupt line
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_reg <= '0;
            inta_n_reg <= 1'b1;
        end else begin
            rdata_reg <= IO.io_rd ? rdata_next : '0;
            inta_n_reg <= !(irq_en_reg && active_reg && !fifo_empty); // R7
        end
    end

    assign IO.io_rdata = rdata_reg;
    assign IO.inta_n = inta_n_reg;
    assign ISO_OUT_BIT = out_reg;
    assign CARD_NUMBER = card_num_reg;
    assign CONV_TRIGGER = trig_reg;
    assign USER_TIMER_OUT = uout_reg;
    assign USER_TIMER_CLK_SYNC = uclk_s2_reg[0];
    assign USER_TIMER_GATE_SYNC = uclk_s2_reg[1];
    assign ACTIVE = active_reg;
    assign INT_PENDING = !inta_n_reg;
    assign SAMPLE_READY = ready_reg;
endmodule : dqc_card

// File: hw/dqc_host.sv
// Host controller: turns software register orders into card I/O cycles
`timescale 1ns/1ps
module dqc_host (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    dqc_io_if.host IO,
    input wire logic [dqc_pkg::ADDR_W-1:0] SW_ADDR,
    input wire logic [dqc_pkg::DATA_W-1:0] SW_WDATA,
    input wire logic SW_WR,
    input wire logic SW_RD,
    output logic [dqc_pkg::DATA_W-1:0] SW_RDATA,
    output logic IRQ
);
    import dqc_pkg::*;

    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg, rdata_reg, sw_rdata_reg;
    logic io_wr_reg, io_rd_reg, rd_wait_reg, byte_reg, irq_reg;
    logic [NUM_EVENTS-1:0] st_reg, en_reg;
    logic [1:0] inta_s_reg;

    wire sel_cmd = SW_WR && SW_ADDR == OFF_CTL_CMD;
    wire go_wr = sel_cmd && SW_WDATA[CMD_WRITE_BIT] && !rd_wait_reg;
    wire go_rd = sel_cmd && SW_WDATA[CMD_READ_BIT] && !SW_WDATA[CMD_WRITE_BIT] && !rd_wait_reg;
    wire clr = SW_WR && SW_ADDR == OFF_CTL_IRQ_CLR;
    wire irq_lvl = !inta_s_reg[1];
    wire [NUM_EVENTS-1:0] ev = {irq_lvl, rd_wait_reg | io_wr_reg};
    wire [NUM_EVENTS-1:0] st_next = ev | (st_reg & ~(clr ? SW_WDATA[NUM_EVENTS-1:0] : '0));
    logic [DATA_W-1:0] sw_rd_mux;
    always_comb begin
        case (SW_ADDR)
            OFF_CTL_ADDR: sw_rd_mux = {{(DATA_W-ADDR_W){1'b0}}, addr_reg};
            OFF_CTL_WDATA: sw_rd_mux = wdata_reg;
            OFF_CTL_RDATA: sw_rd_mux = rdata_reg;
            OFF_CTL_STATUS: sw_rd_mux = {{(DATA_W-NUM_EVENTS-1){1'b0}}, rd_wait_reg, st_reg};
            OFF_CTL_IRQ_EN: sw_rd_mux = {{(DATA_W-NUM_EVENTS){1'b0}}, en_reg};
            default: sw_rd_mux = '0;
        endcase
    end

    // Software side registers
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            addr_reg <= '0;
            wdata_reg <= '0;
            en_reg <= '0;
            st_reg <= '0;
            sw_rdata_reg <= '0;
            irq_reg <= 1'b0;
            inta_s_reg <= 2'h3;
        end else begin
            if (SW_WR && SW_ADDR == OFF_CTL_ADDR) addr_reg <= SW_WDATA[ADDR_W-1:0];
            if (SW_WR && SW_ADDR == OFF_CTL_WDATA) wdata_reg <= SW_WDATA;
            if (SW_WR && SW_ADDR == OFF_CTL_IRQ_EN) en_reg <= SW_WDATA[NUM_EVENTS-1:0];
            st_reg <= st_next;
            sw_rdata_reg <= SW_RD ? sw_rd_mux : '0;
            irq_reg <= |(st_next & en_reg);
            inta_s_reg <= {inta_s_reg[0], IO.inta_n};
        end
    end

    // Card I/O cycle sequencing: strobe one cycle, read data one cycle later
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            io_wr_reg <= 1'b0;
            io_rd_reg <= 1'b0;
            rd_wait_reg <= 1'b0;
            byte_reg <= 1'b0;
            rdata_reg <= '0;
        end else begin
            io_wr_reg <= go_wr;
            io_rd_reg <= go_rd;
            rd_wait_reg <= io_rd_reg;
            if (sel_cmd) byte_reg <= SW_WDATA[CMD_BYTE_BIT]; // R4
            if (rd_wait_reg) rdata_reg <= IO.io_rdata;
        end
    end

    assign IO.io_wr = io_wr_reg;
    assign IO.io_rd = io_rd_reg;
    assign IO.io_addr = addr_reg;
    assign IO.io_wdata = wdata_reg;
    assign IO.io_be = byte_reg ? 4'h1 : 4'hF; // R4
    assign SW_RDATA = sw_rdata_reg;
    assign IRQ = irq_reg;
endmodule : dqc_host

// File: tb/dqc_io_checker.sv
// Concurrent checks on the host to card I/O link
`timescale 1ns/1ps
module dqc_io_checker (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [dqc_pkg::ADDR_W-1:0] io_addr,
    input wire logic [dqc_pkg::DATA_W-1:0] io_wdata,
    input wire logic [3:0] io_be,
    input wire logic [dqc_pkg::DATA_W-1:0] io_rdata,
    input wire logic inta_n
);
    import dqc_pkg::*;
    logic act_reg;
    logic mask_reg;
    logic [7:0] out_reg;
    wire wr_lo = io_wr && io_be[0];
    // Mirror of activation, interrupt mask and output port as seen on the wire
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            act_reg <= 1'b0;
            mask_reg <= 1'b0;
            out_reg <= 8'h00;
        end else begin
            if (wr_lo && io_addr == OFF_BRIDGE_ACTIVATE) act_reg <= io_wdata[ACTIVATE_BIT];
            if (io_wr && io_addr == OFF_IRQ_MASK) mask_reg <= (io_wdata[7:0] == IRQ_MASK_ON);
            if (wr_lo && act_reg && io_addr == OFF_ISO_OUT) out_reg <= io_wdata[7:0];
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    upper_zero_a: assert property (io_rd |=> io_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    idle_zero_a: assert property (!io_rd |=> io_rdata == 32'h00000000)
        else $error("read data outside answer cycle");
    strobe_excl_a: assert property (!(io_wr && io_rd))
        else $error("read and write strobes together");
    access_width_a: assert property ((io_wr || io_rd) |-> (io_be == 4'h1 || io_be == 4'hF))
        else $error("access neither byte nor word");
    mask_off_a: assert property (!mask_reg [*3] |-> inta_n)
        else $error("interrupt line low while masked");
    inactive_quiet_a: assert property (!act_reg [*3] |-> inta_n)
        else $error("interrupt line low while inactive");
    out_readback_a: assert property (io_rd && act_reg && io_addr == OFF_ISO_OUT |=>
        io_rdata == {24'h000000, out_reg}) else $error("output port readback differs");
    unmapped_zero_a: assert property (io_rd && io_addr < 8'hC0 |=> io_rdata == 32'h0)
        else $error("write-only or unmapped read not zero");
endmodule : dqc_io_checker

// File: tb/test_daq_card_host_register_port.sv
// Self-checking bench: host controller and card joined by the I/O link
`timescale 1ns/1ps
module test_daq_card_host_register_port;
    import dqc_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] sw_addr = 8'h00;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [31:0] sw_rdata;
    logic irq, smp_ready, conv_trig, user_out, user_clk_sync, user_gate_sync, card_active;
    logic int_pend;
    logic [7:0] iso_in = 8'h00;
    logic [7:0] iso_out;
    logic [1:0] jumper = 2'h0;
    logic [2:0] card_num;
    logic smp_valid = 1'b0;
    logic [11:0] smp_data = 12'h000;
    logic [3:0] smp_chan = 4'h0;
    logic [2:0] timer_out = 3'h0;
    logic user_clk = 1'b0;
    logic user_gate = 1'b0;
    logic rd_seen = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] rnd;
    logic [11:0] sd[3];
    int errors = 0;
    int compares = 0;
    int trig_cnt = 0;
    int seed = 97016;
    always #2.5 core_clk = ~core_clk;
    dqc_io_if u_dqc_io_if ();
    dqc_card u_dqc_card (.CORE_CLK(core_clk), .RESET_N(reset_n), .IO(u_dqc_io_if),
        .ISO_IN_BIT(iso_in), .ISO_OUT_BIT(iso_out), .CARD_NUMBER_JUMPER(jumper),
        .CARD_NUMBER(card_num), .SAMPLE_VALID(smp_valid), .SAMPLE_DATA(smp_data),
        .SAMPLE_CHAN(smp_chan), .SAMPLE_READY(smp_ready), .CONV_TRIGGER(conv_trig),
        .TIMER_OUT(timer_out), .USER_TIMER_CLK(user_clk), .USER_TIMER_GATE(user_gate),
        .USER_TIMER_OUT(user_out), .USER_TIMER_CLK_SYNC(user_clk_sync),
        .USER_TIMER_GATE_SYNC(user_gate_sync), .ACTIVE(card_active), .INT_PENDING(int_pend));
    dqc_host u_dqc_host (.CORE_CLK(core_clk), .RESET_N(reset_n), .IO(u_dqc_io_if),
        .SW_ADDR(sw_addr), .SW_WDATA(sw_wdata), .SW_WR(sw_wr), .SW_RD(sw_rd),
        .SW_RDATA(sw_rdata), .IRQ(irq));
    dqc_io_checker u_dqc_io_checker (.CORE_CLK(core_clk), .RESET_N(reset_n),
        .io_wr(u_dqc_io_if.io_wr), .io_rd(u_dqc_io_if.io_rd), .io_addr(u_dqc_io_if.io_addr),
        .io_wdata(u_dqc_io_if.io_wdata), .io_be(u_dqc_io_if.io_be),
        .io_rdata(u_dqc_io_if.io_rdata), .inta_n(u_dqc_io_if.inta_n));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check
    task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge core_clk);
        sw_wr <= 1'b0;
    endtask : sw_write
    // Reads note their expected answer for the monitor below
    task automatic sw_read(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge core_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge core_clk);
        sw_rd <= 1'b0;
    endtask : sw_read
    // One card access through the controller's address, data and command registers
    task automatic card_op(input logic wr, input logic [7:0] a, input logic [31:0] d,
        input logic byt, input logic [31:0] e);
        sw_write(OFF_CTL_ADDR, {24'h0, a});
        sw_write(OFF_CTL_WDATA, d);
        sw_write(OFF_CTL_CMD, {29'h0, byt, ~wr, wr});
        repeat (6) @(posedge core_clk);
        if (!wr) sw_read(OFF_CTL_RDATA, e);
    endtask : card_op
    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // Read data stands in the cycle after the strobe; compare it with the oldest note
    always @(posedge core_clk) rd_seen <= sw_rd;
    always @(posedge core_clk) if (conv_trig === 1'b1) trig_cnt++;
    always @(negedge core_clk) begin
        if (rd_seen) check(sw_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 'x, "read");
    end
    // Whole run needs under 2000 cycles; ten times that means a hang
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        for (int j = 0; j < 4; j++) begin
            jumper <= j[1:0];
            repeat (4) @(posedge core_clk);
            check({29'h0, card_num}, j + 1, "card number");
        end
        $display("test card number done");
        // Done interrupt raised, read back, cleared, then disabled
        sw_write(OFF_CTL_IRQ_EN, 32'h1);
        card_op(1'b1, OFF_BRIDGE_SETUP, {24'h0, SETUP_VALUE}, 1'b1, 32'h0);
        check({31'h0, irq}, 32'h1, "done irq");
        sw_read(OFF_CTL_STATUS, 32'h1);
        sw_write(OFF_CTL_IRQ_CLR, 32'h1);
        sw_write(OFF_CTL_IRQ_EN, 32'h0);
        card_op(1'b1, OFF_BRIDGE_ACTIVATE, 32'h1, 1'b0, 32'h0);
        check({31'h0, irq}, 32'h0, "disabled irq");
        check({31'h0, card_active}, 32'h1, "activated");
        $display("test controller irq done");
        // Output port with junk above the low byte, read as zero while inactive
        rnd = $random(seed);
        card_op(1'b1, OFF_ISO_OUT, rnd, 1'b0, 32'h0);
        check({24'h0, iso_out}, {24'h0, rnd[7:0]}, "output pins");
        card_op(1'b0, OFF_ISO_OUT, 32'h0, 1'b0, {24'h0, rnd[7:0]});
        card_op(1'b1, OFF_BRIDGE_ACTIVATE, 32'h0, 1'b0, 32'h0);
        card_op(1'b0, OFF_ISO_OUT, 32'h0, 1'b0, 32'h0);
        card_op(1'b1, OFF_BRIDGE_ACTIVATE, 32'h1, 1'b1, 32'h0);
        card_op(1'b0, OFF_ISO_OUT, 32'h0, 1'b1, {24'h0, rnd[7:0]});
        iso_in <= rnd[15:8];
        repeat (4) @(posedge core_clk);
        card_op(1'b0, OFF_ISO_IN, 32'h0, 1'b0, {24'h0, rnd[15:8]});
        card_op(1'b0, 8'h40, 32'h0, 1'b0, 32'h0);
        $display("test registers done");
        // User timer pins pass through; pacing channels each start one conversion
        user_clk <= 1'b1;
        user_gate <= 1'b1;
        timer_out <= 3'b001;
        repeat (6) @(posedge core_clk);
        check({29'h0, user_clk_sync, user_gate_sync, user_out}, 32'h7, "user timer");
        timer_out <= 3'b011;
        repeat (6) @(posedge core_clk);
        timer_out <= 3'b101;
        repeat (6) @(posedge core_clk);
        check(trig_cnt, 32'd2, "triggers");
        $display("test timers done");
        // Three samples queued, interrupt gated by the mask, then drained in byte reads
        for (int i = 0; i < 3; i++) begin
            sd[i] = 12'($random(seed));
            @(posedge core_clk);
            smp_valid <= 1'b1;
            smp_data <= sd[i];
            smp_chan <= 4'(i * 5);
        end
        @(posedge core_clk);
        smp_valid <= 1'b0;
        repeat (4) @(posedge core_clk);
        check({31'h0, int_pend}, 32'h0, "masked");
        card_op(1'b1, OFF_IRQ_MASK, {24'h0, IRQ_MASK_ON}, 1'b1, 32'h0);
        check({30'h0, int_pend, u_dqc_io_if.inta_n}, 32'h2, "unmasked");
        card_op(1'b1, OFF_IRQ_MASK, {24'h0, IRQ_MASK_OFF}, 1'b1, 32'h0);
        check({31'h0, int_pend}, 32'h0, "masked again");
        card_op(1'b1, OFF_IRQ_MASK, {24'h0, IRQ_MASK_ON}, 1'b1, 32'h0);
        for (int i = 0; i < 3; i++) begin
            card_op(1'b0, OFF_SAMPLE_LOW, 32'h0, 1'b1, {24'h0, sd[i][7:0]});
            card_op(1'b0, OFF_SAMPLE_HIGH, 32'h0, 1'b1, {24'h0, 4'(i * 5), sd[i][11:8]});
        end
        repeat (4) @(posedge core_clk);
        check({31'h0, int_pend}, 32'h0, "drained");
        check({31'h0, smp_ready}, 32'h1, "ready while room");
        // Fill the queue to its depth; the producer must see it refuse more
        smp_valid <= 1'b1;
        repeat (FIFO_DEPTH) @(posedge core_clk);
        smp_valid <= 1'b0;
        repeat (2) @(posedge core_clk);
        check({30'h0, smp_ready, int_pend}, 32'h1, "full queue");
        $display("test sample queue done");
        print_verdict();
    end
endmodule : test_daq_card_host_register_port
